// ### design/tkm_dev_end.sv
`timescale 1ns/1ps
// Function
// - identity: family, serial, check byte
// - check value from x8+x5+x4+1, zero start
// - family lsb first, then serial, into generator
// - receiver sees zero after check bits
// - bytes move least significant bit first
// - memory commands only after identity selection
// - sixteen 32-byte pages plus timekeeping page
// - storage and timekeeping share one address space
// - writes land in scratchpad, copy moves them
// - oscillator enable starts or stops time base
// - snapshot counters after read command byte
// - clock: 40-bit counter, 256 per second
// - interval timer: 40 bits, counts when enabled
// - auto mode: line level qualified by delay
// - manual mode ignores line, run bit selects
// - delay select: long or short delay
// - manual run bit: zero runs, one stops
// - mode bit one auto, zero manual
module tkm_dev_end #(
    parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
    parameter logic [47:0] SERIAL_NUM = 48'h0000_1234_ABCD, // arbitrary value
    parameter int TICK_CYC = tkm_pkg::TICK_CYCLES,
    parameter int DLY_LONG = tkm_pkg::DLY_LONG_CYC,
    parameter int DLY_SHORT = tkm_pkg::DLY_SHORT_CYC
) (
    input logic pclk,
    input logic presetn,
    input logic ce,
    tkm_link_if.dev lnk,
    output logic [39:0] rtc_o,
    output logic [39:0] timer_o,
    output logic [7:0] ctrl_o
);
    import tkm_pkg::*;

    localparam int SRAM_BYTES = SRAM_PAGES * PAGE_BYTES;
    localparam int AW = $clog2(SRAM_BYTES);
    localparam logic [63:0] ROM = {crc_of({SERIAL_NUM, FAMILY_CODE}), SERIAL_NUM, FAMILY_CODE};

    typedef enum logic [12:0] {
        S_IDLE = 13'h0001,
        S_ROMCMD = 13'h0002,
        S_ROMRD = 13'h0004,
        S_MATCH = 13'h0008,
        S_SEARCH = 13'h0010,
        S_MEMCMD = 13'h0020,
        S_ADDR = 13'h0040,
        S_WSP = 13'h0080,
        S_RSP = 13'h0100,
        S_CAUTH = 13'h0200,
        S_COPY = 13'h0400,
        S_RMEM = 13'h0800,
        S_DEAD = 13'h1000
    } tkm_dst_t;

    typedef struct packed {
        tkm_dst_t st;
        logic [7:0] cmd;
        logic [7:0] rxb;
        logic [2:0] rxn;
        logic [7:0] txb;
        logic [2:0] txn;
        logic [6:0] idx;
        logic [1:0] ph;
        logic [15:0] ta;
        logic [7:0] es;
        logic [5:0] ptr;
        logic [7:4] ctl; // numbered as in the control byte
        logic [39:0] rtc;
        logic [39:0] itm;
        logic [39:0] s_rtc;
        logic [39:0] s_itm;
        logic [31:0] pre;
        logic [31:0] qual;
        logic lvl;
        logic d_stb;
        logic d_bit;
    } tkm_dev_t;

    localparam tkm_dev_t DEV_RST = '{st: S_IDLE, ctl: CTL_RST, default: '0};

    tkm_dev_t r;
    tkm_dev_t n;
    logic [7:0] mem [SRAM_BYTES];
    logic [7:0] sp [PAGE_BYTES];
    logic [7:0] nb;
    logic bdone;
    logic tdone;
    logic talk;
    logic tick;
    logic run;
    logic we_sp;
    logic we_mem;
    logic [15:0] wa;
    logic [7:0] wd;
    logic [31:0] dly;
    int wk;

    function automatic logic [7:0] rd_byte(input logic [15:0] a);
        int k;
        k = int'(a) - int'(ADDR_RTC);
        if (a < 16'(SRAM_BYTES)) return mem[a[AW-1:0]];
        if (a == ADDR_CTRL) return {r.ctl, 4'h0};
        if (k >= 0 && k < CNT_BYTES) return r.s_rtc[8*k +: 8];
        if (k >= CNT_BYTES && k < 2 * CNT_BYTES) return r.s_itm[8*(k-CNT_BYTES) +: 8];
        if (a <= PAGE16_END) return 8'h00;
        return 8'hFF;
    endfunction

    always_comb begin
        n = r;
        n.d_stb = 1'b0;
        n.d_bit = 1'b1;
        we_sp = 1'b0;
        we_mem = 1'b0;
        wa = {r.ta[15:5], r.ptr[4:0]};
        wd = sp[r.ptr[4:0]];
        wk = int'(wa) - int'(ADDR_RTC);
        nb = {lnk.h_bit, r.rxb[7:1]};
        bdone = lnk.h_stb && r.rxn == 3'd7;
        talk = r.st == S_ROMRD || r.st == S_RSP || r.st == S_RMEM;
        tdone = lnk.r_req && talk && r.txn == 3'd7;
        if (lnk.h_stb) begin
            n.rxb = nb;
            n.rxn = r.rxn + 3'd1;
        end
        if (lnk.r_req) begin
            n.d_stb = 1'b1;
            if (talk) begin
                n.d_bit = r.txb[r.txn];
                n.txn = r.txn + 3'd1;
            end
        end

        // time base and counters
        tick = r.ctl[CTL_OSC] && r.pre == 32'(TICK_CYC - 1);
        if (r.ctl[CTL_OSC]) begin
            n.pre = tick ? 32'h0000_0000 : r.pre + 32'h0000_0001;
        end
        dly = r.ctl[CTL_TRANSITION_DELAY_SELECT] ? 32'(DLY_LONG) : 32'(DLY_SHORT);
        if (lnk.line_hi != r.lvl) begin
            if (r.qual >= dly - 32'h0000_0001) begin
                n.lvl = lnk.line_hi;
                n.qual = 32'h0000_0000;
            end else begin
                n.qual = r.qual + 32'h0000_0001;
            end
        end else begin
            n.qual = 32'h0000_0000;
        end
        run = r.ctl[CTL_AUTO] ? r.lvl : ~r.ctl[CTL_STOP];
        if (tick) begin
            n.rtc = r.rtc + 40'h00_0000_0001;
            if (run) begin
                n.itm = r.itm + 40'h00_0000_0001;
            end
        end

        case (r.st)
            S_IDLE: begin
            end
            S_ROMCMD: begin
                if (bdone) begin
                    n.idx = 7'd0;
                    n.ph = 2'd0;
                    n.txn = 3'd0;
                    case (nb)
                        ROM_READ: begin
                            n.st = S_ROMRD;
                            n.txb = ROM[7:0];
                        end
                        ROM_MATCH: n.st = S_MATCH;
                        ROM_SEARCH: n.st = S_SEARCH;
                        ROM_SKIP: n.st = S_MEMCMD;
                        default: n.st = S_DEAD;
                    endcase
                end
            end
            S_ROMRD: begin
                if (tdone) begin
                    n.idx = r.idx + 7'd1;
                    n.txb = ROM[{r.idx[2:0] + 3'd1, 3'b000} +: 8];
                    if (r.idx == 7'd7) begin
                        n.st = S_MEMCMD;
                    end
                end
            end
            S_MATCH: begin
                if (lnk.h_stb) begin
                    n.idx = r.idx + 7'd1;
                    if (lnk.h_bit != ROM[r.idx[5:0]]) begin
                        n.st = S_DEAD;
                    end else if (r.idx == 7'd63) begin
                        n.st = S_MEMCMD;
                    end
                end
            end
            S_SEARCH: begin
                if (lnk.r_req && r.ph != 2'd2) begin
                    n.d_bit = ROM[r.idx[5:0]] ^ r.ph[0];
                    n.ph = r.ph + 2'd1;
                end else if (lnk.h_stb && r.ph == 2'd2) begin
                    n.ph = 2'd0;
                    n.idx = r.idx + 7'd1;
                    if (lnk.h_bit != ROM[r.idx[5:0]]) begin
                        n.st = S_DEAD;
                    end else if (r.idx == 7'd63) begin
                        n.st = S_MEMCMD;
                    end
                end
            end
            S_MEMCMD: begin
                if (bdone) begin
                    n.cmd = nb;
                    n.idx = 7'd0;
                    n.txn = 3'd0;
                    n.txb = r.ta[7:0];
                    case (nb)
                        MEM_RD: begin
                            n.st = S_ADDR;
                            n.s_rtc = r.rtc;
                            n.s_itm = r.itm;
                        end
                        MEM_WSP: n.st = S_ADDR;
                        MEM_RSP: n.st = S_RSP;
                        MEM_CPY: n.st = S_CAUTH;
                        default: n.st = S_DEAD;
                    endcase
                end
            end
            S_ADDR: begin
                if (bdone && r.idx == 7'd0) begin
                    n.ta[7:0] = nb;
                    n.idx = 7'd1;
                end else if (bdone) begin
                    n.ta[15:8] = nb;
                    n.txn = 3'd0;
                    n.ptr = {1'b0, r.ta[4:0]};
                    if (r.cmd == MEM_RD) begin
                        n.st = S_RMEM;
                        n.txb = rd_byte({nb, r.ta[7:0]});
                    end else begin
                        n.st = S_WSP;
                        n.es = {3'b000, r.ta[4:0]};
                    end
                end
            end
            S_WSP: begin
                if (bdone && r.ptr[5]) begin
                    n.es[6] = 1'b1;
                end else if (bdone) begin
                    we_sp = 1'b1;
                    n.es[4:0] = r.ptr[4:0];
                    n.ptr = r.ptr + 6'd1;
                end
            end
            S_RSP: begin
                if (tdone) begin
                    if (r.idx == 7'd0) begin
                        n.txb = r.ta[15:8];
                        n.idx = 7'd1;
                    end else if (r.idx == 7'd1) begin
                        n.txb = r.es;
                        n.idx = 7'd2;
                        n.ptr = {1'b0, r.ta[4:0]};
                    end else begin
                        n.txb = r.ptr[5] ? 8'hFF : sp[r.ptr[4:0]];
                        n.ptr = r.ptr[5] ? r.ptr : r.ptr + 6'd1;
                    end
                end
            end
            S_CAUTH: begin
                if (bdone) begin
                    n.idx = r.idx + 7'd1;
                    n.ptr = {1'b0, r.ta[4:0]};
                    if (nb != (r.idx == 7'd0 ? r.ta[7:0] : r.idx == 7'd1 ? r.ta[15:8] : r.es)) begin
                        n.st = S_DEAD;
                    end else if (r.idx == 7'd2) begin
                        n.st = S_COPY;
                    end
                end
            end
            S_COPY: begin
                if (wa < 16'(SRAM_BYTES)) begin
                    we_mem = 1'b1;
                end else if (wa == ADDR_CTRL) begin
                    n.ctl = wd[7:4];
                end else if (wk >= 0 && wk < CNT_BYTES) begin
                    n.rtc[8*wk +: 8] = wd;
                end else if (wk >= CNT_BYTES && wk < 2 * CNT_BYTES) begin
                    n.itm[8*(wk-CNT_BYTES) +: 8] = wd;
                end
                n.ptr = r.ptr + 6'd1;
                if (r.ptr[4:0] == r.es[4:0]) begin
                    n.es[7] = 1'b1;
                    n.st = S_DEAD;
                end
            end
            S_RMEM: begin
                if (tdone) begin
                    n.ta = r.ta + 16'h0001;
                    n.txb = rd_byte(r.ta + 16'h0001);
                end
            end
            S_DEAD: begin
            end
            default: n.st = S_IDLE;
        endcase

        if (n.st == S_MEMCMD && r.st != S_MEMCMD) begin
            n.rxn = 3'd0;
        end
        // frame start: only identity selection is accepted next
        if (lnk.rst_pulse) begin
            if (r.st == S_WSP && r.rxn != 3'd0 && !r.es[6]) begin
                n.es[5] = 1'b1;
            end
            n.st = S_ROMCMD;
            n.rxn = 3'd0;
            n.txn = 3'd0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= DEV_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    always_ff @(posedge pclk) begin
        if (ce && we_sp) begin
            sp[r.ptr[4:0]] <= nb;
        end
        if (ce && we_mem) begin
            mem[wa[AW-1:0]] <= wd;
        end
    end

    assign lnk.d_stb = r.d_stb;
    assign lnk.d_bit = r.d_bit;
    assign rtc_o = r.rtc;
    assign timer_o = r.itm;
    assign ctrl_o = {r.ctl, 4'h0};
endmodule // tkm_dev_end

// ### design/tkm_host_end.sv
`timescale 1ns/1ps
module tkm_host_end (
    input logic pclk,
    input logic presetn,
    input logic ce,
    input logic psel,
    input logic penable,
    input logic pwrite,
    input logic [7:0] paddr,
    input logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    tkm_link_if.host lnk
);
    import tkm_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE = 3'b001,
        H_SEND = 3'b010,
        H_RECV = 3'b100
    } tkm_hst_t;

    typedef struct packed {
        tkm_hst_t st;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic wt;
        logic [7:0] rxd;
        logic [7:0] crc;
        logic line_hi;
        logic rst;
        logic h_stb;
        logic h_bit;
        logic r_req;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tkm_host_t;

    localparam tkm_host_t HOST_RST = '{st: H_IDLE, crc: CRC_INIT, line_hi: 1'b1, default: '0};

    tkm_host_t r;
    tkm_host_t n;
    logic acc;
    logic wr;

    always_comb begin
        n = r;
        n.rst = 1'b0;
        n.h_stb = 1'b0;
        n.r_req = 1'b0;
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        acc = psel && penable && !r.pready;
        wr = psel && penable && pwrite && r.pready;

        case (r.st)
            H_IDLE: begin
            end
            H_SEND: begin
                n.h_stb = 1'b1;
                n.h_bit = r.sh[0];
                n.sh = r.sh >> 1;
                n.crc = crc_step(r.crc, r.sh[0]);
                n.cnt = r.cnt - 4'd1;
                if (r.cnt == 4'd1) begin
                    n.st = H_IDLE;
                end
            end
            H_RECV: begin
                if (!r.wt) begin
                    n.r_req = 1'b1;
                    n.wt = 1'b1;
                end else if (lnk.d_stb) begin
                    n.wt = 1'b0;
                    n.rxd = {lnk.d_bit, r.rxd[7:1]};
                    n.crc = crc_step(r.crc, lnk.d_bit);
                    n.cnt = r.cnt - 4'd1;
                    if (r.cnt == 4'd1) begin
                        n.st = H_IDLE;
                    end
                end
            end
            default: n.st = H_IDLE;
        endcase

        // apb: data prepared one cycle into access, effect at completion
        if (acc) begin
            n.pready = 1'b1;
            n.prdata = 32'h0000_0000;
            case (paddr)
                REG_CMD: begin
                end
                REG_STAT: n.prdata = {8'h00, r.crc, r.rxd, 7'h00, r.st != H_IDLE};
                REG_CFG: n.prdata = {31'h0000_0000, ~r.line_hi};
                default: n.pslverr = 1'b1;
            endcase
        end
        if (wr && paddr == REG_CFG) begin
            n.line_hi = ~pwdata[0];
            if (pwdata[1]) begin
                n.crc = CRC_INIT;
            end
        end
        if (wr && paddr == REG_CMD && r.st == H_IDLE) begin
            n.wt = 1'b0;
            n.sh = pwdata[15:8];
            case (pwdata[2:0])
                OP_RESET: n.rst = 1'b1;
                OP_WBYTE: begin
                    n.st = H_SEND;
                    n.cnt = 4'd8;
                end
                OP_WBIT: begin
                    n.st = H_SEND;
                    n.cnt = 4'd1;
                end
                OP_RBYTE: begin
                    n.st = H_RECV;
                    n.cnt = 4'd8;
                end
                OP_RBIT: begin
                    n.st = H_RECV;
                    n.cnt = 4'd1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= HOST_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign lnk.rst_pulse = r.rst;
    assign lnk.h_stb = r.h_stb;
    assign lnk.h_bit = r.h_bit;
    assign lnk.r_req = r.r_req;
    assign lnk.line_hi = r.line_hi;
endmodule // tkm_host_end

// ### design/tkm_link_if.sv
`timescale 1ns/1ps
interface tkm_link_if;
    logic rst_pulse;
    logic h_stb;
    logic h_bit;
    logic r_req;
    logic d_stb;
    logic d_bit;
    logic line_hi;
    modport dev(input rst_pulse, input h_stb, input h_bit, input r_req, input line_hi, output d_stb, output d_bit);
    modport host(output rst_pulse, output h_stb, output h_bit, output r_req, output line_hi, input d_stb, input d_bit);
endinterface

// ### design/tkm_pkg.sv
package tkm_pkg;
    // system clock and time base
    localparam int CLK_HZ = 200_000_000;
    localparam int TICKS_PER_S = 256;
    localparam int TICK_CYCLES = CLK_HZ / TICKS_PER_S;
    // line qualification delays in microseconds and in cycles
    localparam int DLY_LONG_US = 123_000;
    localparam int DLY_SHORT_US = 3_500;
    localparam int DLY_LONG_CYC = DLY_LONG_US * (CLK_HZ / 1_000_000);
    localparam int DLY_SHORT_CYC = DLY_SHORT_US * (CLK_HZ / 1_000_000);

    // identity selection commands
    localparam logic [7:0] ROM_READ = 8'h33;
    localparam logic [7:0] ROM_MATCH = 8'h55;
    localparam logic [7:0] ROM_SEARCH = 8'hF0;
    localparam logic [7:0] ROM_SKIP = 8'hCC;
    // memory commands
    localparam logic [7:0] MEM_WSP = 8'h0F;
    localparam logic [7:0] MEM_RSP = 8'hAA;
    localparam logic [7:0] MEM_CPY = 8'h55;
    localparam logic [7:0] MEM_RD = 8'hF0;

    // check value feedback, reflected form of x^8 + x^5 + x^4 + 1
    localparam logic [7:0] CRC_REFL = 8'h8C;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // memory map
    localparam int PAGE_BYTES = 32;
    localparam int SRAM_PAGES = 16;
    localparam logic [15:0] ADDR_STATUS = 16'h0200;
    localparam logic [15:0] ADDR_CTRL = 16'h0201;
    localparam logic [15:0] ADDR_RTC = 16'h0202;
    localparam logic [15:0] ADDR_ITM = 16'h0207;
    localparam logic [15:0] PAGE16_END = 16'h021D;
    localparam int CNT_BYTES = 5;

    // control byte fields
    localparam int CTL_TRANSITION_DELAY_SELECT = 7;
    localparam int CTL_STOP = 6;
    localparam int CTL_AUTO = 5;
    localparam int CTL_OSC = 4;
    localparam logic [3:0] CTL_RST = 4'h0;

    // host registers and operations
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [2:0] OP_RESET = 3'h1;
    localparam logic [2:0] OP_WBYTE = 3'h2;
    localparam logic [2:0] OP_RBYTE = 3'h3;
    localparam logic [2:0] OP_WBIT = 3'h4;
    localparam logic [2:0] OP_RBIT = 3'h5;

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        return (c >> 1) ^ (fb ? CRC_REFL : 8'h00);
    endfunction

    function automatic logic [7:0] crc_of(input logic [55:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 56; i++) begin
            c = crc_step(c, d[i]);
        end
        return c;
    endfunction
endpackage

// ### verif/timekeeping_memory_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); end end
module timekeeping_memory_core_tb_top;
    import tkm_pkg::*;
    localparam logic [7:0] FAM = 8'hA7; // arbitrary value
    localparam logic [47:0] SER = 48'h0031_C4E2_9B06; // arbitrary value
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errv;
    logic [7:0] paddr = 8'h00, ctrl_o;
    logic [31:0] pwdata = 32'h0, prdata, rdv;
    logic [39:0] rtc_o, timer_o;
    int failures = 0, samples_checked = 0, cycles = 0;
    tkm_link_if lnk();
    tkm_dev_end #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .TICK_CYC(8), .DLY_LONG(40), .DLY_SHORT(10)) u_tkm_dev_end (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .lnk(lnk.dev), .rtc_o(rtc_o), .timer_o(timer_o), .ctrl_o(ctrl_o));
    tkm_host_end u_tkm_host_end (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lnk(lnk.host));
    tkm_props u_tkm_props (.pclk(pclk), .presetn(presetn), .rst_pulse(lnk.rst_pulse), .h_stb(lnk.h_stb),
        .r_req(lnk.r_req), .d_stb(lnk.d_stb), .rtc_o(rtc_o), .timer_o(timer_o), .ctrl_o(ctrl_o));
    initial forever #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            $display("ERROR %0t: timeout", $time);
            close_out();
        end
    end
    function automatic logic [7:0] ref_crc(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
        end
        return c;
    endfunction
    task automatic close_out();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, prdata and pslverr read as they stand at the completing edge
        do @(posedge pclk); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic op(input logic [2:0] o, input logic [7:0] b);
        apb(1'b1, REG_CMD, {16'h0000, b, 5'h00, o});
        do apb(1'b0, REG_STAT, 32'h0); while (rdv[0] !== 1'b0);
    endtask
    task automatic rdb(output logic [7:0] b);
        op(OP_RBYTE, 8'hFF);
        b = rdv[15:8];
    endtask
    task automatic frame(input logic [7:0] c);
        op(OP_RESET, 8'h00);
        op(OP_WBYTE, c);
    endtask
    task automatic sendq(input logic [7:0] q[$]);
        foreach (q[i]) op(OP_WBYTE, q[i]);
    endtask
    task automatic t_identity();
        logic [63:0] id;
        frame(ROM_READ);
        op(OP_RBIT, 8'h00);
        `CHK(rdv[15], FAM[0])
        frame(ROM_READ);
        apb(1'b1, REG_CFG, 32'h2);
        for (int i = 0; i < 8; i++) rdb(id[i*8 +: 8]);
        `CHK(id[55:0], {SER, FAM})
        `CHK(id[63:56], ref_crc({SER, FAM}))
        apb(1'b0, REG_STAT, 32'h0);
        `CHK(rdv[23:16], 8'h00)
        $display("t_identity done");
    endtask
    task automatic t_refuse();
        logic [7:0] b;
        frame(MEM_WSP);
        sendq('{8'h00, 8'h02, MEM_RD, 8'h00, 8'h02});
        rdb(b);
        `CHK(b, 8'hFF)
        frame(ROM_SKIP);
        sendq('{MEM_RD, 8'h00, 8'h02});
        rdb(b);
        `CHK(b, 8'h00)
        apb(1'b0, 8'h0C, 32'h0);
        `CHK({errv, rdv}, 33'h1_0000_0000)
        $display("t_refuse done");
    endtask
    task automatic set_ctrl(input logic [7:0] v);
        logic [7:0] old, b;
        logic [7:0] e[4];
        old = ctrl_o;
        e = '{8'h01, 8'h02, 8'h01, v};
        frame(ROM_SKIP);
        sendq('{MEM_WSP, 8'h01, 8'h02, v});
        frame(ROM_SKIP);
        op(OP_WBYTE, MEM_RSP);
        for (int i = 0; i < 4; i++) begin
            rdb(b);
            `CHK(b, e[i])
        end
        `CHK(ctrl_o, old)
        frame(ROM_SKIP);
        sendq('{MEM_CPY, 8'h01, 8'h02, 8'h01});
        repeat (4) @(posedge pclk);
        `CHK(ctrl_o, v)
    endtask
    task automatic delta(input int n, input logic [39:0] er, input logic [39:0] et);
        logic [39:0] r0, t0;
        @(negedge pclk);
        r0 = rtc_o;
        t0 = timer_o;
        repeat (n) @(negedge pclk);
        `CHK(rtc_o - r0, er)
        `CHK(timer_o - t0, et)
    endtask
    task automatic t_time();
        set_ctrl(8'h10);
        delta(80, 40'd10, 40'd10);
        set_ctrl(8'h50);
        delta(80, 40'd10, 40'd0);
        set_ctrl(8'h00);
        delta(80, 40'd0, 40'd0);
        set_ctrl(8'h30);
        delta(80, 40'd10, 40'd10);
        apb(1'b1, REG_CFG, 32'h1);
        repeat (15) @(posedge pclk);
        delta(80, 40'd10, 40'd0);
        set_ctrl(8'hB0);
        apb(1'b1, REG_CFG, 32'h0);
        repeat (12) @(posedge pclk);
        delta(16, 40'd2, 40'd0);
        repeat (30) @(posedge pclk);
        delta(80, 40'd10, 40'd10);
        $display("t_time done");
    endtask
    task automatic t_wrap();
        logic [7:0] q[$];
        set_ctrl(8'h00);
        // zeros first, so no byte write ever looks like a tick
        for (int k = 0; k < 2; k++) begin
            q = {MEM_WSP, 8'h02, 8'h02};
            repeat (2 * CNT_BYTES) q.push_back(k == 0 ? 8'h00 : 8'hFF);
            frame(ROM_SKIP);
            sendq(q);
            frame(ROM_SKIP);
            sendq('{MEM_CPY, 8'h02, 8'h02, 8'h0B});
        end
        repeat (12) @(posedge pclk);
        `CHK({rtc_o, timer_o}, {80{1'b1}})
        set_ctrl(8'h10);
        repeat (16) @(posedge pclk);
        `CHK(rtc_o < 40'h00_0000_0010 && timer_o < 40'h00_0000_0010, 1'b1)
        $display("t_wrap done");
    endtask
    task automatic t_snapshot();
        logic [39:0] v, r0;
        frame(ROM_SKIP);
        r0 = rtc_o;
        sendq('{MEM_RD, 8'h02, 8'h02});
        for (int i = 0; i < 5; i++) rdb(v[i*8 +: 8]);
        `CHK(v >= r0 && v < rtc_o, 1'b1)
        $display("t_snapshot done");
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_identity();
        t_refuse();
        t_time();
        t_wrap();
        t_snapshot();
        close_out();
    end
endmodule // timekeeping_memory_core_tb_top

// ### verif/tkm_props.sv
`timescale 1ns/1ps
module tkm_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rst_pulse,
    input wire logic h_stb,
    input wire logic r_req,
    input wire logic d_stb,
    input wire logic [39:0] rtc_o,
    input wire logic [39:0] timer_o,
    input wire logic [7:0] ctrl_o
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pacing check assumes the bench's tick period of 8 cycles
    chk_bit_answer: assert property (r_req |=> d_stb)
        else $error("bit request got no answer");
    chk_answer_cause: assert property (d_stb |-> $past(r_req))
        else $error("answer without request");
    chk_req_spacing: assert property (r_req |=> !r_req)
        else $error("requests back to back");
    chk_rst_alone: assert property (rst_pulse |-> !h_stb && !r_req)
        else $error("frame start mixed with bit traffic");
    chk_rst_single: assert property (rst_pulse |=> !rst_pulse)
        else $error("frame start longer than one cycle");
    chk_rtc_needs_osc: assert property (rtc_o == $past(rtc_o) + 40'h1 |-> $past(ctrl_o[4]))
        else $error("clock advanced with oscillator off");
    chk_timer_gated: assert property (timer_o == $past(timer_o) + 40'h1 |->
        $past(ctrl_o[4]) && ($past(ctrl_o[5]) || !$past(ctrl_o[6])))
        else $error("timer advanced while stopped");
    chk_rtc_paced: assert property (rtc_o == $past(rtc_o) + 40'h1 |=> $stable(rtc_o) [*7])
        else $error("clock ticks too close");
    cover property (d_stb);
    cover property (rst_pulse);
    cover property (timer_o == $past(timer_o) + 40'h1);
endmodule // tkm_props
